// ==== rtl/spindle_cfg.svh ====
`ifndef SPINDLE_CFG_SVH
`define SPINDLE_CFG_SVH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_VSET 8'h04
`define OFS_STAT 8'h08
`define OFS_VMEAS 8'h0c
`define OFS_ECC 8'h10
`define OFS_OSC 8'h14

// control register fields
`define CTRL_MODE_LSB 0
`define CTRL_DSPEED 2
`define CTRL_LOW_POWER_SELECT 3
`define CTRL_PWMMD 4
`define CTRL_FLOFF 5
`define CTRL_RANGE_LSB 6
`define CTRL_CAVPWM 8

// reset values
`define CTRL_RESET 32'h0000_0000
`define VSET_RESET 8'he0

// timing
`define CLK_HZ 40000000
`define LOCK_SAMPLE_HZ 460
`define LOCK_SAMPLE_CYC (`CLK_HZ / `LOCK_SAMPLE_HZ)
`define REF_HZ 132300
`define REF_HALF_CYC (`CLK_HZ / (2 * `REF_HZ))
`define LOCK_RUN 8
`define REL_VEL_DIV 32

`endif

// ==== rtl/spindle_pkg.sv ====
package spindle_pkg;
	typedef enum logic [1:0] {
		normal_linear_mode,
		wide_linear_mode,
		angular_velocity_mode,
		osc_control_mode
	} op_mode_e;

	typedef logic [9:0] vel_count_t;
endpackage

// ==== rtl/vel_meas_if.sv ====
`timescale 1ns/100ps
interface vel_meas_if;
	logic use_master_clock;
	logic [9:0] count;
	logic done;

	modport ctrl (output use_master_clock, input count, input done);
	modport meter (input use_master_clock, output count, output done);
endinterface

// ==== rtl/velocity_meter.sv ====
`timescale 1ns/100ps
`include "spindle_cfg.svh"
module velocity_meter #(
	parameter int REF_HALF = `REF_HALF_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic external_osc_clock_in,
	input wire logic variable_master_clock,
	vel_meas_if.meter vm
);
	logic [1:0] ext_sync_q, ext_sync_d;
	logic [1:0] mst_sync_q, mst_sync_d;
	logic prev_q, prev_d;
	logic half_q, half_d;
	logic ref_q, ref_d;
	logic [15:0] ref_cnt_q, ref_cnt_d;
	spindle_pkg::vel_count_t acc_q, acc_d, res_q, res_d;
	logic done_q, done_d;
	logic pick;

	// pins are asynchronous: two stages before use
	always_comb begin
		ext_sync_d = {ext_sync_q[0], external_osc_clock_in};
		mst_sync_d = {mst_sync_q[0], variable_master_clock};
		// measured clock: master clock in angular mode, ext osc in wide
		pick = vm.use_master_clock ? mst_sync_q[1] : ext_sync_q[1];
		prev_d = pick;
		half_d = half_q;
		acc_d = acc_q;
		res_d = res_q;
		done_d = 1'b0;
		ref_cnt_d = ref_cnt_q + 16'h0001;
		ref_d = ref_q;
		if (ref_cnt_q == 16'(REF_HALF - 1)) begin
			ref_cnt_d = 16'h0000;
			ref_d = ~ref_q;
		end
		if (ref_q) begin
			// count every second rising edge: half-rate pulses
			if (pick && !prev_q) begin
				half_d = ~half_q;
				if (half_q && acc_q != 10'h3ff)
					acc_d = acc_q + 10'h001;
			end
			if (ref_d == 1'b0) begin
				res_d = acc_d;
				done_d = 1'b1;
			end
		end else begin
			acc_d = 10'h000;
			half_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ext_sync_q <= 2'h0;
			mst_sync_q <= 2'h0;
			prev_q <= 1'b0;
			half_q <= 1'b0;
			ref_q <= 1'b0;
			ref_cnt_q <= 16'h0000;
			acc_q <= 10'h000;
			res_q <= 10'h000;
			done_q <= 1'b0;
		end else begin
			ext_sync_q <= ext_sync_d;
			mst_sync_q <= mst_sync_d;
			prev_q <= prev_d;
			half_q <= half_d;
			ref_q <= ref_d;
			ref_cnt_q <= ref_cnt_d;
			acc_q <= acc_d;
			res_q <= res_d;
			done_q <= done_d;
		end
	end

	assign vm.count = res_q;
	assign vm.done = done_q;
endmodule

// ==== rtl/disc_spindle_mode_control.sv ====
// What this block does
// - report 10-bit count, speed is (m+1)/32
// - wide mode counts half ext oscillator pulses
// - count 31 normal, 63 double speed
// - normal mode: legacy servo, 150 kHz capture
// - wide mode: loop tracks disc, linear servo
// - low power drops deceleration pulses in wide
// - wide mode drives ternary output only
// - angular speed from setting or pwm input
// - pwm input high kicks, low brakes
// - angular mode counts half master clock pulses
// - angular count 31 normal, 127 quadruple
// - angular mode system timing follows disc
// - oscillator word from range times (256-n)
// - first oscillator ratio 49/24 or 49/16
// - first-stage status three-bit encoding
// - second-stage status three-bit encoding
// - lock flag: eight equal samples at 460 Hz
// - loop-off disables frequency loop
`timescale 1ns/100ps
`include "spindle_cfg.svh"
module disc_spindle_mode_control #(
	parameter int LOCK_SAMPLE_CYC = `LOCK_SAMPLE_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic external_osc_clock_in,
	input wire logic variable_master_clock,
	input wire logic external_pwm_in,
	input wire logic frame_sync_good,
	input wire logic servo_accel,
	input wire logic servo_decel,
	input wire logic [1:0] c1_corrected,
	input wire logic c1_fail,
	input wire logic c1_pointer,
	input wire logic [2:0] c2_corrected,
	input wire logic c2_fail,
	input wire logic c2_pointer_copy,
	output logic spindle_accel,
	output logic spindle_decel,
	output logic spindle_pwm_active,
	output logic wide_lock_flag,
	output logic freq_loop_off,
	output logic pll_wide_capture,
	output logic pll_track_velocity,
	output logic sys_clock_follow_disc,
	output logic osc_use_setting,
	output logic [9:0] osc_freq_word,
	output logic [5:0] first_osc_num,
	output logic [5:0] first_osc_den,
	output logic [9:0] relative_velocity_count
);
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	function automatic logic [2:0] enc_first(input logic [1:0] n,
			input logic fail, input logic ptr);
		// pointer set moves the code into the 1xx half
		if (fail)
			enc_first = 3'h7;
		else if (ptr || n == 2'h2)
			enc_first = {1'b1, n};
		else
			enc_first = {1'b0, n};
	endfunction

	function automatic logic [2:0] enc_second(input logic [2:0] n,
			input logic fail, input logic copy);
		// 101 is never produced
		if (fail)
			enc_second = copy ? 3'h6 : 3'h7;
		else if (n > 3'h4)
			enc_second = 3'h4;
		else
			enc_second = n;
	endfunction

	vel_meas_if vm ();

	velocity_meter u_meter (
		.clk(clk),
		.nrst(nrst),
		.external_osc_clock_in(external_osc_clock_in),
		.variable_master_clock(variable_master_clock),
		.vm(vm)
	);

	// register state
	spindle_pkg::op_mode_e mode_q, mode_d;
	logic [6:0] ctrl_q, ctrl_d;
	logic [7:0] vset_q, vset_d;
	logic [2:0] ecc1_q, ecc1_d, ecc2_q, ecc2_d;
	logic [9:0] vel_q, vel_d;

	// bus state
	logic aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [1:0] rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;

	// lock, pin sync and drive state
	logic [1:0] gfs_sync_q, gfs_sync_d;
	logic [1:0] pwm_sync_q, pwm_sync_d;
	logic [16:0] tick_cnt_q, tick_cnt_d;
	logic [3:0] run_q, run_d;
	logic run_level_q, run_level_d;
	logic lock_q, lock_d;
	logic acc_q, acc_d, dec_q, dec_d;
	logic [31:0] rd_word;
	logic rd_ok;
	logic do_write;
	logic [9:0] target;

	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign do_write = aw_have_q && w_have_q && !bvalid_q;
	assign target = 10'h100 - {2'h0, vset_q};

	// read mux
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		if (s_axi_araddr == `OFS_CTRL)
			rd_word = {23'h0, ctrl_q[6], ctrl_q[5:0], mode_q};
		else if (s_axi_araddr == `OFS_VSET)
			rd_word = {24'h0, vset_q};
		else if (s_axi_araddr == `OFS_STAT)
			rd_word = {28'h0, mode_q, gfs_sync_q[1], lock_q};
		else if (s_axi_araddr == `OFS_VMEAS)
			rd_word = {22'h0, vel_q};
		else if (s_axi_araddr == `OFS_ECC)
			rd_word = {25'h0, ecc2_q, 1'b0, ecc1_q};
		else if (s_axi_araddr == `OFS_OSC)
			rd_word = {10'h0, first_osc_num, first_osc_den, osc_freq_word};
		else
			rd_ok = 1'b0;
	end

	// bus handshake and register writes
	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		mode_d = mode_q;
		ctrl_d = ctrl_q;
		vset_d = vset_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (do_write) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_OK;
			if (awaddr_q == `OFS_CTRL) begin
				if (wstrb_q[0]) begin
					// only a mode command changes the mode
					mode_d = spindle_pkg::op_mode_e'(
						wdata_q[`CTRL_MODE_LSB +: 2]);
					ctrl_d[5:0] = wdata_q[7:2];
				end
				if (wstrb_q[1])
					ctrl_d[6] = wdata_q[`CTRL_CAVPWM];
			end else if (awaddr_q == `OFS_VSET) begin
				if (wstrb_q[0])
					vset_d = wdata_q[7:0];
			end else if (awaddr_q == `OFS_STAT || awaddr_q == `OFS_VMEAS
					|| awaddr_q == `OFS_ECC || awaddr_q == `OFS_OSC) begin
				bresp_d = RESP_OK;
			end else begin
				bresp_d = RESP_ERR;
			end
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rdata_d = rd_word;
			rresp_d = rd_ok ? RESP_OK : RESP_ERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rresp_q <= 2'h0;
			rdata_q <= 32'h0000_0000;
			mode_q <= spindle_pkg::normal_linear_mode;
			ctrl_q <= 7'h00;
			vset_q <= `VSET_RESET;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			mode_q <= mode_d;
			ctrl_q <= ctrl_d;
			vset_q <= vset_d;
		end
	end

	// lock detection, measurement capture, status encoding, drive
	always_comb begin
		gfs_sync_d = {gfs_sync_q[0], frame_sync_good};
		pwm_sync_d = {pwm_sync_q[0], external_pwm_in};
		tick_cnt_d = tick_cnt_q + 17'h00001;
		run_d = run_q;
		run_level_d = run_level_q;
		lock_d = lock_q;
		if (tick_cnt_q == 17'(LOCK_SAMPLE_CYC - 1)) begin
			tick_cnt_d = 17'h00000;
			// count equal samples in a row
			if (gfs_sync_q[1] != run_level_q) begin
				run_level_d = gfs_sync_q[1];
				run_d = 4'h1;
			end else if (run_q != 4'(`LOCK_RUN)) begin
				run_d = run_q + 4'h1;
			end
			if (run_d == 4'(`LOCK_RUN))
				lock_d = run_level_d;
		end
		// the count alone is kept; speed is (m+1)/32 in software
		vel_d = vm.done ? vm.count : vel_q;
		ecc1_d = enc_first(c1_corrected, c1_fail, c1_pointer);
		ecc2_d = enc_second(c2_corrected, c2_fail, c2_pointer_copy);
		acc_d = 1'b0;
		dec_d = 1'b0;
		case (mode_q)
			spindle_pkg::normal_linear_mode: begin
				acc_d = servo_accel;
				dec_d = servo_decel;
			end
			spindle_pkg::wide_linear_mode: begin
				acc_d = servo_accel;
				dec_d = servo_decel && !ctrl_q[`CTRL_LOW_POWER_SELECT - 2];
			end
			spindle_pkg::angular_velocity_mode: begin
				if (ctrl_q[6]) begin
					acc_d = pwm_sync_q[1];
					dec_d = !pwm_sync_q[1];
				end else begin
					// closed loop on measured count against 256-n
					acc_d = vel_q < target;
					dec_d = vel_q > target;
				end
			end
			spindle_pkg::osc_control_mode: begin
				acc_d = servo_accel;
				dec_d = servo_decel;
			end
			default: begin
				acc_d = 1'b0;
				dec_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gfs_sync_q <= 2'h0;
			pwm_sync_q <= 2'h0;
			tick_cnt_q <= 17'h00000;
			run_q <= 4'h0;
			run_level_q <= 1'b0;
			lock_q <= 1'b0;
			vel_q <= 10'h000;
			ecc1_q <= 3'h0;
			ecc2_q <= 3'h0;
			acc_q <= 1'b0;
			dec_q <= 1'b0;
		end else begin
			gfs_sync_q <= gfs_sync_d;
			pwm_sync_q <= pwm_sync_d;
			tick_cnt_q <= tick_cnt_d;
			run_q <= run_d;
			run_level_q <= run_level_d;
			lock_q <= lock_d;
			vel_q <= vel_d;
			ecc1_q <= ecc1_d;
			ecc2_q <= ecc2_d;
			acc_q <= acc_d;
			dec_q <= dec_d;
		end
	end

	// the meter watches the master clock only in angular mode
	assign vm.use_master_clock =
		(mode_q == spindle_pkg::angular_velocity_mode);

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign spindle_accel = acc_q;
	assign spindle_decel = dec_q;
	// pwm drive is never used in wide mode
	assign spindle_pwm_active = ctrl_q[`CTRL_PWMMD - 2]
		&& (mode_q != spindle_pkg::wide_linear_mode);
	assign wide_lock_flag = lock_q;
	assign freq_loop_off = ctrl_q[`CTRL_FLOFF - 2];
	assign pll_wide_capture = (mode_q != spindle_pkg::normal_linear_mode);
	assign pll_track_velocity = (mode_q == spindle_pkg::wide_linear_mode);
	assign sys_clock_follow_disc =
		(mode_q == spindle_pkg::angular_velocity_mode);
	assign osc_use_setting = (mode_q == spindle_pkg::osc_control_mode);
	// master clock frequency word, range times (256-n), scaled by 1/32
	assign osc_freq_word = 10'(({8'h00, ctrl_q[5:4]} * target) >> 5);
	assign first_osc_num = 6'h31;
	assign first_osc_den = ctrl_q[`CTRL_DSPEED - 2] ? 6'h10 : 6'h18;
	assign relative_velocity_count = vel_q;
endmodule

// ==== tb/spindle_properties.sv ====
`timescale 1ns/100ps
module spindle_properties #(
	parameter int LOCK_SAMPLE_CYC = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_arready,
	input wire logic frame_sync_good,
	input wire logic spindle_accel,
	input wire logic spindle_decel,
	input wire logic spindle_pwm_active,
	input wire logic wide_lock_flag,
	input wire logic pll_track_velocity,
	input wire logic sys_clock_follow_disc,
	input wire logic [9:0] osc_freq_word,
	input wire logic [5:0] first_osc_num,
	input wire logic [5:0] first_osc_den
);
	// raw run lengths; the sync stage only lengthens what the flag needs
	int hi_q, lo_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hi_q <= 0;
			lo_q <= 0;
		end else begin
			hi_q <= frame_sync_good ? hi_q + 1 : 0;
			lo_q <= frame_sync_good ? 0 : lo_q + 1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	lock_rise_a: assert property (
		$rose(wide_lock_flag) |-> hi_q >= 7 * LOCK_SAMPLE_CYC)
		else $error("lock rose early");
	lock_fall_a: assert property (
		$fell(wide_lock_flag) |-> lo_q >= 7 * LOCK_SAMPLE_CYC)
		else $error("lock fell early");
	lock_set_a: assert property (
		hi_q == 10 * LOCK_SAMPLE_CYC |-> wide_lock_flag)
		else $error("lock not set");
	lock_clear_a: assert property (
		lo_q == 10 * LOCK_SAMPLE_CYC |-> !wide_lock_flag)
		else $error("lock not cleared");
	drive_ternary_a: assert property (
		!(spindle_accel && spindle_decel))
		else $error("accel and decel together");
	wide_no_pwm_a: assert property (
		pll_track_velocity |-> !spindle_pwm_active)
		else $error("pwm drive in wide mode");
	one_mode_a: assert property (
		!(pll_track_velocity && sys_clock_follow_disc))
		else $error("two modes at once");
	osc_ratio_a: assert property (
		first_osc_num == 6'h31 && (first_osc_den == 6'h18
		|| first_osc_den == 6'h10))
		else $error("bad oscillator ratio");
	osc_word_max_a: assert property (
		osc_freq_word <= 10'h18)
		else $error("oscillator word out of range");
	read_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	one_resp_a: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	cover property ($rose(wide_lock_flag));
	cover property ($fell(wide_lock_flag));
	cover property (spindle_pwm_active);
endmodule

// ==== tb/disc_far.sv ====
`timescale 1ns/100ps
// spinning disc: about 31 counted pulses per reference high phase
module disc_far #(
	parameter real HALF = 30.2
) (
	input wire logic spin,
	input wire logic use_ext,
	output logic external_osc_clock_in,
	output logic variable_master_clock
);
	logic t = 1'b0;
	// stands still low when not spinning
	always #(HALF) t = spin ? !t : 1'b0;
	assign external_osc_clock_in = use_ext & t;
	assign variable_master_clock = !use_ext & t;
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/100ps
module tb;
	logic clk, nrst, spin, use_ext;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, c1_corrected, r;
	logic [2:0] c2_corrected;
	logic [9:0] osc_freq_word, relative_velocity_count;
	logic [5:0] first_osc_num, first_osc_den;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, external_osc_clock_in;
	logic variable_master_clock, external_pwm_in, frame_sync_good;
	logic servo_accel, servo_decel, c1_fail, c1_pointer, c2_fail;
	logic c2_pointer_copy, spindle_accel, spindle_decel, osc_use_setting;
	logic spindle_pwm_active, wide_lock_flag, freq_loop_off;
	logic pll_wide_capture, pll_track_velocity, sys_clock_follow_disc;
	int fails, check_count, i;
	disc_spindle_mode_control #(
		.LOCK_SAMPLE_CYC(16)
	) u_disc_spindle_mode_control (
		.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .external_osc_clock_in,
		.variable_master_clock, .external_pwm_in, .frame_sync_good,
		.servo_accel, .servo_decel, .c1_corrected, .c1_fail, .c1_pointer,
		.c2_corrected, .c2_fail, .c2_pointer_copy, .spindle_accel,
		.spindle_decel, .spindle_pwm_active, .wide_lock_flag,
		.freq_loop_off, .pll_wide_capture, .pll_track_velocity,
		.sys_clock_follow_disc, .osc_use_setting, .osc_freq_word,
		.first_osc_num, .first_osc_den, .relative_velocity_count);
	disc_far u_disc_far (.spin, .use_ext, .external_osc_clock_in,
		.variable_master_clock);
	task automatic conclude;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic lim(input int n, input int m);
		if (n >= m) begin
			fails++;
			conclude();
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		r = s_axi_bresp;
		lim(n, 20);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		lim(n, 20);
	endtask
	// the controller polls status until the lock flag reaches v
	task automatic lk(input logic v);
		int n;
		for (n = 0; n < 100; n++) begin
			rd(8'h08);
			if (d[0] === v) break;
		end
		lim(n, 100);
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		{nrst, spin, use_ext, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, external_pwm_in, frame_sync_good} = '0;
		{servo_accel, servo_decel, c1_fail, c1_pointer, c2_fail} = '0;
		{c2_pointer_copy, c1_corrected, c2_corrected} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		wt(2);
		nrst <= 1'b1;
		@(posedge clk);
		chk(first_osc_den, 32'h18);
		rd(8'h04);
		chk(d, 32'he0);
		rd(8'h40);
		chk(r, 32'h2);
		wr(8'h08, 32'hf);
		chk(r, 32'h0);
		rd(8'h08);
		chk(d[3:2], 32'h0);
		wr(8'h04, 32'h10);
		wr(8'h00, 32'hc7);
		chk(osc_freq_word, 32'h16);
		chk(osc_use_setting, 32'h1);
		chk(pll_wide_capture, 32'h1);
		rd(8'h14);
		chk(d, 32'h0031_4016);
		for (i = 0; i < 8; i++) begin
			c1_corrected <= (i == 6) ? 2'h2 : {1'b0, i[0]};
			c1_pointer <= i[1];
			c1_fail <= i == 7;
			c2_corrected <= i[2:0];
			c2_fail <= i > 4;
			c2_pointer_copy <= i == 5;
			wt(2);
			rd(8'h10);
			chk(d, {25'h0, i < 5 ? i[2:0] : (i == 5 ? 3'h6 : 3'h7), 1'b0,
				i == 7 ? 3'h7 : {i[1], i == 6, i[0]}});
		end
		wr(8'h04, 32'hd8);
		wr(8'h00, 32'h22);
		spin <= 1'b1;
		wt(800);
		chk(sys_clock_follow_disc, 32'h1);
		chk(freq_loop_off, 32'h1);
		rd(8'h0c);
		chk(d >= 30 && d <= 32, 32'h1);
		chk(relative_velocity_count, d);
		chk({spindle_accel, spindle_decel}, 32'h2);
		wr(8'h04, 32'hf0);
		wt(4);
		chk({spindle_accel, spindle_decel}, 32'h1);
		wr(8'h00, 32'h122);
		rd(8'h00);
		chk(d, 32'h122);
		for (i = 0; i < 2; i++) begin
			external_pwm_in <= !i[0];
			wt(5);
			chk({spindle_accel, spindle_decel}, i ? 32'h1 : 32'h2);
		end
		use_ext <= 1'b1;
		frame_sync_good <= 1'b1;
		servo_decel <= 1'b1;
		lk(1'b1);
		chk(wide_lock_flag, 32'h1);
		wr(8'h00, 32'h01);
		chk(pll_track_velocity, 32'h1);
		wt(700);
		rd(8'h0c);
		chk(d >= 30 && d <= 32, 32'h1);
		chk({spindle_accel, spindle_decel}, 32'h1);
		wr(8'h00, 32'h09);
		wt(3);
		chk(spindle_decel, 32'h0);
		wr(8'h00, 32'h11);
		chk(spindle_pwm_active, 32'h0);
		frame_sync_good <= 1'b0;
		lk(1'b0);
		chk(wide_lock_flag, 32'h0);
		wr(8'h00, 32'h22);
		rd(8'h08);
		chk(d[3:2], 32'h2);
		wr(8'h00, 32'h10);
		chk(spindle_pwm_active, 32'h1);
		chk({pll_wide_capture, osc_use_setting}, 32'h0);
		servo_accel <= 1'b1;
		servo_decel <= 1'b0;
		// long enough for the low run to reach the lock checker's limit
		wt(40);
		chk({spindle_accel, spindle_decel}, 32'h2);
		conclude();
	end
endmodule
bind disc_spindle_mode_control spindle_properties #(
	.LOCK_SAMPLE_CYC(LOCK_SAMPLE_CYC)
) u_spindle_properties (.clk, .nrst, .s_axi_bvalid, .s_axi_bready,
	.s_axi_rvalid, .s_axi_arready, .frame_sync_good, .spindle_accel,
	.spindle_decel, .spindle_pwm_active, .wide_lock_flag,
	.pll_track_velocity, .sys_clock_follow_disc, .osc_freq_word,
	.first_osc_num, .first_osc_den);
